// ===== pkg/wdtp_pkg.sv
/*
 Constants, types and timing counts shared by the postscaled watchdog.
 Assumes a single 50 MHz system clock standing in for the internal RC source.
*/
// What this block does
// - The watchdog counts on the internal RC clock, and enabling it also enables that clock.
// - The watchdog base period is a nominal 4 ms taken from the internal RC clock.
// - The base period drives a 16-bit postscaler, so the timeout is base period times ratio.
// - A multiplexer steered by the period select field picks the postscaler output used.
// - Selectable timeouts run from 4 ms up to 131.072 s at the largest ratio.
// - A sleep or clear watchdog instruction clears both the counter and the postscaler.
// - A clock failure on the primary or Timer1 oscillator clears counter and postscaler.
// - The watchdog control register can be written and read back by software.
// - The software watchdog enable bit switches watchdog operation on or off.
// - Software can turn the watchdog on or off only when the config bit leaves it off.
package wdtp_pkg;

	// timing
	localparam int CLK_PERIOD_NS  = 20;
	localparam int BASE_PERIOD_US = 4000;
	localparam int BASE_CYCLES    = (BASE_PERIOD_US * 1000) / CLK_PERIOD_NS;
	localparam int MAX_TIMEOUT_MS = 131072;

	// postscaler
	localparam int PS_WIDTH  = 16;
	localparam int SEL_WIDTH = 4;

	// watchdog control register layout
	localparam int         CTRL_WIDTH    = 8;
	localparam int         CTRL_SWEN_BIT = 0;
	localparam int         CTRL_ACT_BIT  = 1;
	localparam int         CTRL_TO_BIT   = 2;
	localparam logic [0:0] SWEN_RESET    = 1'h0;

	typedef enum logic [1:0] {
		WD_OFF,
		WD_RUN,
		WD_FIRE
	} wdtp_state_t;

endpackage

// ===== verilog/wdtp_base_divider.sv
/*
 Base period divider: one-cycle tick every CYCLES clocks while enabled.
 Assumes clear and enable are synchronous to clk_sys.
*/
`timescale 1ns/100ps
module wdtp_base_divider #(
	parameter int CYCLES = wdtp_pkg::BASE_CYCLES
) (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic reset,
	// control
	input  wire logic enable,
	input  wire logic clear,
	// base tick
	output logic      tick
);
	localparam int CW = $clog2(CYCLES);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
	} wdtp_div_t;

	wdtp_div_t div_reg;
	wdtp_div_t div_next;

	if (CYCLES < 2) begin : g_chk
		$error("base divider needs at least two cycles");
	end

	always_comb begin
		div_next = div_reg;
		tick     = 1'b0;
		if (clear || !enable) begin
			div_next.cnt = '0;
		end else if (div_reg.cnt == LAST) begin
			div_next.cnt = '0;
			tick         = 1'b1;
		end else begin
			div_next.cnt = div_reg.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_next;
		end
	end

	a_div_clear_holds: assert property (@(posedge clk_sys) disable iff (reset)
		clear |=> (div_reg.cnt == '0) && !tick)
		else $error("divider not cleared");

endmodule

// ===== verilog/wdtp_postscaler.sv
/*
 Postscaler: counts base ticks; output bit select chooses a ratio of 2**select.
 Assumes tick is a one-cycle pulse and select is static while counting.
*/
`timescale 1ns/100ps
module wdtp_postscaler #(
	parameter int WIDTH = wdtp_pkg::PS_WIDTH,
	parameter int SELW  = wdtp_pkg::SEL_WIDTH
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             reset,
	// control
	input  wire logic             clear,
	input  wire logic             tick,
	input  wire logic [SELW-1:0]  select,
	// result
	output logic                  expire,
	output logic      [WIDTH-1:0] count
);
	typedef struct packed {
		logic [WIDTH-1:0] cnt;
	} wdtp_ps_t;

	wdtp_ps_t   ps_reg;
	wdtp_ps_t   ps_next;
	logic [WIDTH-1:0] terminal;

	if (WIDTH < 1 || (1 << SELW) > WIDTH) begin : g_chk
		$error("select range must match postscaler width");
	end

	// terminal[i]: low i bits all ones, ratio 2**i
	for (genvar i = 0; i < WIDTH; i++) begin : g_term
		if (i == 0) begin : g_zero
			assign terminal[i] = 1'b1;
		end else begin : g_more
			assign terminal[i] = &ps_reg.cnt[i-1:0];
		end
	end

	always_comb begin
		ps_next = ps_reg;
		expire  = tick && terminal[select];
		if (clear) begin
			ps_next.cnt = '0;
		end else if (expire) begin
			ps_next.cnt = '0;
		end else if (tick) begin
			ps_next.cnt = ps_reg.cnt + 1'b1;
		end
	end

	assign count = ps_reg.cnt;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ps_reg <= '0;
		end else begin
			ps_reg <= ps_next;
		end
	end

endmodule

// ===== verilog/wdtp_watchdog.sv
/*
 Postscaled watchdog top: enable logic, control register, clearing sources,
 base divider, postscaler multiplexer and timeout event outputs.
 Assumes instruction strobes and clock-fail flags are one-cycle, synchronous pulses.
*/
`timescale 1ns/100ps
module wdtp_watchdog #(
	parameter int BASE_CYCLES = wdtp_pkg::BASE_CYCLES
) (
	// clock and reset
	input  wire logic                            clk_sys,
	input  wire logic                            reset,
	// configuration
	input  wire logic                            configWatchdogEnable,
	input  wire logic [wdtp_pkg::SEL_WIDTH-1:0]  periodSelectField,
	// instruction execution
	input  wire logic                            clearWatchdogInstruction,
	input  wire logic                            sleepInstruction,
	input  wire logic                            sleeping,
	// clock failure detection
	input  wire logic                            clockFailPrimary,
	input  wire logic                            clockFailTimer1,
	// watchdog control register access
	input  wire logic                            ctrlWrite,
	input  wire logic [wdtp_pkg::CTRL_WIDTH-1:0] ctrlWriteData,
	output logic      [wdtp_pkg::CTRL_WIDTH-1:0] ctrlReadData,
	// status and events
	output logic                                 rcOscEnable,
	output logic                                 watchdogActive,
	output logic                                 timeoutReset,
	output logic                                 timeoutWake
);
	typedef struct packed {
		wdtp_pkg::wdtp_state_t state;
		logic                  swEnable;
		logic                  timedOut;
		logic                  resetPulse;
		logic                  wakePulse;
	} wdtp_top_t;

	wdtp_top_t top_reg;
	wdtp_top_t top_next;

	logic active;
	logic clearAll;
	logic baseTick;
	logic expire;
	logic [wdtp_pkg::PS_WIDTH-1:0] psCount;

	if (BASE_CYCLES < 2) begin : g_chk
		$error("base period too short");
	end

	// config enable forces the watchdog on; software can only add to it
	assign active = configWatchdogEnable || top_reg.swEnable;

	// instruction and clock failure clears
	assign clearAll = clearWatchdogInstruction || sleepInstruction
		|| clockFailPrimary || clockFailTimer1;

	wdtp_base_divider #(
		.CYCLES (BASE_CYCLES)
	) u_div (
		.clk_sys (clk_sys),
		.reset   (reset),
		.enable  (active),
		.clear   (clearAll),
		.tick    (baseTick)
	);

	wdtp_postscaler #(
		.WIDTH (wdtp_pkg::PS_WIDTH),
		.SELW  (wdtp_pkg::SEL_WIDTH)
	) u_ps (
		.clk_sys (clk_sys),
		.reset   (reset),
		.clear   (clearAll || !active),
		.tick    (baseTick),
		.select  (periodSelectField),
		.expire  (expire),
		.count   (psCount)
	);

	always_comb begin
		top_next            = top_reg;
		top_next.resetPulse = 1'b0;
		top_next.wakePulse  = 1'b0;
		if (ctrlWrite) begin
			top_next.swEnable = ctrlWriteData[wdtp_pkg::CTRL_SWEN_BIT];
		end
		// timeout flag: set wins over the clear instruction
		if (clearWatchdogInstruction) begin
			top_next.timedOut = 1'b0;
		end
		case (top_reg.state)
			wdtp_pkg::WD_OFF: begin
				if (active) begin
					top_next.state = wdtp_pkg::WD_RUN;
				end
			end
			wdtp_pkg::WD_RUN: begin
				if (!active) begin
					top_next.state = wdtp_pkg::WD_OFF;
				end else if (expire) begin
					top_next.state      = wdtp_pkg::WD_FIRE;
					top_next.timedOut   = 1'b1;
					top_next.resetPulse = !sleeping;
					top_next.wakePulse  = sleeping;
				end
			end
			wdtp_pkg::WD_FIRE: begin
				top_next.state = active ? wdtp_pkg::WD_RUN : wdtp_pkg::WD_OFF;
			end
			default: begin
				top_next.state = wdtp_pkg::WD_OFF;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			top_reg            <= '0;
			top_reg.state      <= wdtp_pkg::WD_OFF;
			top_reg.swEnable   <= wdtp_pkg::SWEN_RESET;
		end else begin
			top_reg <= top_next;
		end
	end

	// rc source runs whenever the watchdog does
	assign rcOscEnable    = active;
	assign watchdogActive = active;
	assign timeoutReset   = top_reg.resetPulse;
	assign timeoutWake    = top_reg.wakePulse;

	always_comb begin
		ctrlReadData                          = '0;
		ctrlReadData[wdtp_pkg::CTRL_SWEN_BIT] = top_reg.swEnable;
		ctrlReadData[wdtp_pkg::CTRL_ACT_BIT]  = active;
		ctrlReadData[wdtp_pkg::CTRL_TO_BIT]   = top_reg.timedOut;
	end

	// helper counters for the checks below
	localparam longint BASE_L   = longint'(BASE_CYCLES);
	localparam longint MAX_TO_L = (longint'(wdtp_pkg::MAX_TIMEOUT_MS) * 1000000)
		/ longint'(wdtp_pkg::CLK_PERIOD_NS);

	logic [63:0] tickGap;
	logic [63:0] toGap;

	always_ff @(posedge clk_sys) begin
		if (reset || clearAll || !active || baseTick) begin
			tickGap <= '0;
		end else begin
			tickGap <= tickGap + 64'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset || clearAll || !active || expire) begin
			toGap <= '0;
		end else begin
			toGap <= toGap + 64'h1;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	sequence s_instr_clear;
		clearWatchdogInstruction || sleepInstruction;
	endsequence

	sequence s_fail_clear;
		clockFailPrimary || clockFailTimer1;
	endsequence

	sequence s_counts_zero;
		(psCount == '0) && (u_div.div_reg.cnt == '0) && !expire;
	endsequence

	sequence s_no_event;
		!timeoutReset && !timeoutWake;
	endsequence

	sequence s_any_clear;
		clearWatchdogInstruction || sleepInstruction
			|| clockFailPrimary || clockFailTimer1;
	endsequence

	// expiry followed by its one-cycle event
	sequence s_timeout_event;
		expire ##1 (timeoutReset || timeoutWake);
	endsequence

	a_osc_follows_wdt: assert property (
		rcOscEnable == (configWatchdogEnable || ctrlReadData[wdtp_pkg::CTRL_SWEN_BIT]))
		else $error("rc source not tied to watchdog enable");

	a_base_tick_gap: assert property (
		baseTick |-> tickGap == 64'(BASE_L - 1))
		else $error("base tick spacing wrong");

	a_postscale_ratio: assert property (
		expire |-> toGap == 64'((BASE_L << periodSelectField) - 1))
		else $error("timeout is not base times ratio");

	a_mux_select_bit: assert property (
		expire |-> baseTick
			&& ((psCount & 16'((1 << periodSelectField) - 1))
			== 16'((1 << periodSelectField) - 1)))
		else $error("postscaler output chosen wrongly");

	a_timeout_range: assert property (
		expire |-> (toGap >= 64'(BASE_L - 1)) && (toGap < 64'(MAX_TO_L)))
		else $error("timeout outside selectable range");

	a_instr_clears: assert property (
		s_instr_clear |=> s_counts_zero)
		else $error("instruction did not clear counts");

	a_fail_clears: assert property (
		s_fail_clear |=> s_counts_zero)
		else $error("clock failure did not clear counts");

	a_ctrl_readback: assert property (
		ctrlWrite |=> ctrlReadData[wdtp_pkg::CTRL_SWEN_BIT]
			== $past(ctrlWriteData[wdtp_pkg::CTRL_SWEN_BIT]))
		else $error("control register readback wrong");

	a_sw_turns_on: assert property (
		(ctrlWrite && ctrlWriteData[wdtp_pkg::CTRL_SWEN_BIT])
			|=> watchdogActive ##1 (watchdogActive || $past(ctrlWrite)))
		else $error("software enable did not start watchdog");

	a_config_locks_on: assert property (
		configWatchdogEnable |-> watchdogActive
			&& ctrlReadData[wdtp_pkg::CTRL_ACT_BIT])
		else $error("software disabled a config-enabled watchdog");

	a_timeout_reset: assert property (
		(expire && !sleeping && top_reg.state == wdtp_pkg::WD_RUN)
			|=> timeoutReset && !timeoutWake ##1 !timeoutReset)
		else $error("running timeout did not reset");

	a_timeout_wake: assert property (
		(expire && sleeping && top_reg.state == wdtp_pkg::WD_RUN)
			|=> timeoutWake && !timeoutReset
			&& ctrlReadData[wdtp_pkg::CTRL_TO_BIT])
		else $error("sleeping timeout did not wake");

	// checks beyond one assertion per rule
	a_events_exclusive: assert property (
		!(timeoutReset && timeoutWake))
		else $error("reset and wake events together");

	a_idle_no_event: assert property (
		!watchdogActive |=> s_no_event)
		else $error("timeout event while disabled");

	a_idle_counts_held: assert property (
		!watchdogActive |=> (psCount == '0)
			&& (u_div.div_reg.cnt == '0))
		else $error("counts not held while disabled");

	a_tick_needs_active: assert property (
		!watchdogActive |-> !baseTick)
		else $error("base tick without rc source");

	a_flag_sticky: assert property (
		(ctrlReadData[wdtp_pkg::CTRL_TO_BIT] && !clearWatchdogInstruction)
			|=> ctrlReadData[wdtp_pkg::CTRL_TO_BIT])
		else $error("timed out flag lost");

	a_flag_cleared: assert property (
		(clearWatchdogInstruction && !expire)
			|=> !ctrlReadData[wdtp_pkg::CTRL_TO_BIT])
		else $error("clear instruction kept timed out flag");

	a_event_after_expire: assert property (
		(timeoutReset || timeoutWake) |-> $past(expire))
		else $error("timeout event without expiry");

	a_wake_when_asleep: assert property (
		timeoutWake |-> $past(sleeping))
		else $error("wake event while running");

	a_reset_when_running: assert property (
		timeoutReset |-> !$past(sleeping))
		else $error("reset event while asleep");

	a_fire_state_brief: assert property (
		(top_reg.state == wdtp_pkg::WD_FIRE)
			|=> (top_reg.state != wdtp_pkg::WD_FIRE))
		else $error("fire state held too long");

	a_ctrl_unused_zero: assert property (
		ctrlReadData[wdtp_pkg::CTRL_WIDTH-1:wdtp_pkg::CTRL_TO_BIT+1] == '0)
		else $error("unused control bits not zero");

	a_clear_blocks_event: assert property (
		s_any_clear |=> s_no_event ##1 s_no_event)
		else $error("timeout event right after a clear");

	a_event_one_cycle: assert property (
		s_timeout_event |=> s_no_event)
		else $error("timeout event longer than one cycle");

endmodule

// ===== tb/testbench.sv
/*
 Self-checking bench for the postscaled watchdog top, with a shortened base period.
 Assumes the design drives the timeout event outputs from registers and samples inputs on clk_sys rising edges.
*/
`timescale 1ns/100ps
module testbench;
	localparam int BASE = 4;
	logic       clk_sys;
	logic       reset;
	logic       cfgEn;
	logic [3:0] sel;
	logic       clrIns;
	logic       slpIns;
	logic       sleeping;
	logic       failPri;
	logic       failT1;
	logic       ctrlWrite;
	logic [7:0] wrData;
	logic [7:0] rdData;
	logic       rcOscEnable;
	logic       watchdogActive;
	logic       timeoutReset;
	logic       timeoutWake;
	int         numErrors;
	int         nTests;
	int         seed;
	int         p;
	int         d;

	wdtp_watchdog #(.BASE_CYCLES(BASE)) dut (
		.clk_sys(clk_sys), .reset(reset), .configWatchdogEnable(cfgEn),
		.periodSelectField(sel), .clearWatchdogInstruction(clrIns),
		.sleepInstruction(slpIns), .sleeping(sleeping), .clockFailPrimary(failPri),
		.clockFailTimer1(failT1), .ctrlWrite(ctrlWrite), .ctrlWriteData(wrData),
		.ctrlReadData(rdData), .rcOscEnable(rcOscEnable), .watchdogActive(watchdogActive),
		.timeoutReset(timeoutReset), .timeoutWake(timeoutWake)
	);

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			numErrors++;
			$display("BAD %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task finish_test;
		$display("comparisons %0d mismatches %0d", nTests, numErrors);
		if (numErrors == 0 && nTests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	function int period(input logic [3:0] s);
		return BASE << s;
	endfunction

	// one-cycle strobe; waits an edge first so back-to-back calls never re-raise it at once
	task write_ctrl(input logic [7:0] v);
		@(negedge clk_sys);
		wrData = v;
		ctrlWrite = 1'b1;
		@(negedge clk_sys);
		ctrlWrite = 1'b0;
	endtask

	task pulse(input int src);
		case (src)
			0: clrIns = 1'b1;
			1: slpIns = 1'b1;
			2: failPri = 1'b1;
			default: failT1 = 1'b1;
		endcase
		@(negedge clk_sys);
		{clrIns, slpIns, failPri, failT1} = 4'h0;
	endtask

	// counts from the first fresh cycle to the timeout event
	task measure(input int expP, input logic wake);
		int   n;
		logic ev;
		n = 1;
		ev = wake ? timeoutWake : timeoutReset;
		while (ev !== 1'b1 && n < expP + 8) begin
			@(negedge clk_sys);
			n++;
			ev = wake ? timeoutWake : timeoutReset;
		end
		check("timeout cycles", n, expP + 1);
		check("other event", wake ? timeoutReset : timeoutWake, 0);
		check("timed out flag", rdData[2], 1);
		if (n >= expP + 8) begin
			numErrors++;
			finish_test();
		end
		@(negedge clk_sys);
		check("event width", wake ? timeoutWake : timeoutReset, 0);
	endtask

	initial begin
		seed = 32'h1e27;
		reset = 1'b1;
		cfgEn = 1'b0;
		sel = 4'h0;
		{clrIns, slpIns, sleeping, failPri, failT1, ctrlWrite} = 6'h00;
		wrData = 8'h00;
		repeat (6) @(negedge clk_sys);
		reset = 1'b0;
		check("read after reset", rdData, 8'h00);
		check("osc after reset", rcOscEnable, 0);
		write_ctrl(8'hff);
		check("read sw on", rdData, 8'h03);
		check("osc sw on", rcOscEnable, 1);
		write_ctrl(8'h00);
		check("read sw off", rdData, 8'h00);
		for (int i = 0; i < 3 * BASE; i++) begin
			@(negedge clk_sys);
			check("idle events", {timeoutReset, timeoutWake}, 0);
		end
		$display("test register and disable done");
		cfgEn = 1'b1;
		@(negedge clk_sys);
		check("forced active", watchdogActive, 1);
		write_ctrl(8'h00);
		check("sw cannot stop", watchdogActive, 1);
		check("osc forced", rcOscEnable, 1);
		pulse(0);
		measure(period(sel), 1'b0);
		cfgEn = 1'b0;
		@(negedge clk_sys);
		check("config off", watchdogActive, 0);
		$display("test config enable done");
		for (int i = 0; i < 8; i++) begin
			if (i == 7)
				sel = 4'hb;
			else
				sel = (i == 0) ? 4'h0 : 4'($unsigned($random(seed)) % 8);
			sleeping = 1'($random(seed));
			p = period(sel);
			write_ctrl(8'h01);
			measure(p, sleeping);
			d = $unsigned($random(seed)) % (p - 2);
			repeat (d) @(negedge clk_sys);
			if (i % 4 == 1)
				sleeping = 1'b1;
			pulse(i % 4);
			if (i % 4 == 0)
				check("flag cleared", rdData[2], 0);
			measure(p, sleeping);
			write_ctrl(8'h00);
			$display("test timeout sel %0d source %0d done", sel, i % 4);
		end
		finish_test();
	end
endmodule
